// File: core/block_erase_lock_ctrl.sv
// Purpose: command front end for block erase and block locking
// Assumes: synchronous command port, one write or read per cycle
// Notes: erase and program busy times are cycle counts
//
// Functional notes
// - erase runs after 20h then D0h
// - only one partition erasing, others reading
// - confirm write address picks the block
// - finished erase leaves block all ones
// - ready bit low during erase, high after
// - confirm puts partition in status mode
// - broken erase sequence flags error, blocks erases
// - only clear-status clears error bits
// - status error encoding per bit
// - supply or lock error refuses erase
// - status mode stays until next command
// - program and erase together is error
// - suspended erase, program, read coexist
// - reset leaves every block locked
// - erase of locked block sets bit 1
// - erase only in unlocked lock states
// - lock code is pin, lock-down, lock
// - pin low holds locked-down block frozen
// - pin high releases locked-down blocks
// - lock-down bit cleared by reset only
// - identifier read at base plus 02h
// - locks ignore supply, erase needs supply
// - lock sequence 60h then 01h/D0h/2Fh
// - bad code after 60h is sequence error
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
module block_erase_lock_ctrl
  import erase_lock_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
)
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic wp_n_i,
  input wire logic supply_ok_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic engine_ready_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // partition field of an address
  function automatic logic [PART_W-1:0] part_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: PART_W];
  endfunction

  // block field of an address
  function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: BLK_W];
  endfunction

  // lock code {pin, lock-down, lock} to protected flag
  function automatic logic is_locked(input logic [2:0] code);
    return code[0] | (code[1] & ~code[2]);
  endfunction

  // errors that refuse a new erase
  function automatic logic erase_blocked(input logic [7:0] err);
    return err[3] | err[1] | (err[5] & err[4]);
  endfunction

  // status word of one partition
  function automatic logic [7:0] status_of(input logic [7:0] err, input logic busy, input logic susp);
    logic [7:0] s;
    s = err & SR_ERR_MASK;
    if (!busy)
    begin
      s = s | SR_READY;
    end
    if (susp)
    begin
      s = s | SR_ESUSP;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  pend_t pend_q; // pending setup code
  pend_t pend_d;
  logic [PART_W-1:0] pend_part_q; // partition of the setup write
  logic [PART_W-1:0] pend_part_d;
  mode_t mode_q [NUM_PART]; // read mode per partition
  mode_t mode_d [NUM_PART];
  logic [7:0] err_q [NUM_PART]; // sticky error bits per partition
  logic [7:0] err_set [NUM_PART]; // error bits raised this cycle
  logic [NUM_PART-1:0] err_clr; // clear-status hit per partition
  erase_st_t e_st_q; // erase engine state
  logic [CNT_W-1:0] e_cnt_q; // erase cycles left
  logic [BLK_W-1:0] e_blk_q; // block under erase
  logic [PART_W-1:0] e_part_q; // partition under erase
  logic prog_busy_q; // program running
  logic [CNT_W-1:0] p_cnt_q; // program cycles left
  logic [PART_W-1:0] p_part_q; // partition programming
  logic [NUM_BLK-1:0] erased_q; // block reads all ones
  logic [NUM_BLK-1:0] lock_w; // lock bits from the bank
  logic [NUM_BLK-1:0] lockdown_w; // lock-down bits from the bank
  logic start_erase; // erase accepted this cycle
  logic start_prog; // program accepted this cycle
  logic erase_done; // erase finishes this cycle
  logic lock_op; // lock command to the bank
  logic do_suspend; // suspend a running erase
  logic do_resume; // resume a suspended erase
  logic [7:0] cmd; // command byte
  logic [PART_W-1:0] wp; // write partition
  logic [BLK_W-1:0] wb; // write block
  logic [PART_W-1:0] rp; // read partition
  logic [BLK_W-1:0] rb; // read block
  logic wb_locked; // write block protected
  logic rb_locked; // read block protected

  assign cmd = wr_data_i[7:0];
  assign wp = part_of(cmd_addr_i);
  assign wb = blk_of(cmd_addr_i);
  assign rp = part_of(cmd_addr_i);
  assign rb = blk_of(cmd_addr_i);
  assign wb_locked = is_locked({wp_n_i, lockdown_w[wb], lock_w[wb]});
  assign rb_locked = is_locked({wp_n_i, lockdown_w[rb], lock_w[rb]});
  assign erase_done = (e_st_q == E_RUN) && (e_cnt_q == '0);

  ////////////////////////////////////////////////////////////////////////////
  // command front end decode
  always_comb
  begin
    pend_d = pend_q;
    pend_part_d = pend_part_q;
    mode_d = mode_q;
    err_set = '{default: SR_NONE};
    err_clr = '0;
    start_erase = 1'b0;
    start_prog = 1'b0;
    lock_op = 1'b0;
    do_suspend = 1'b0;
    do_resume = 1'b0;
    if (wr_en_i)
    begin
      pend_d = P_NONE;
      unique case (pend_q)
        P_ERASE:
        begin
          if (cmd == CMD_CONFIRM)
          begin
            mode_d[wp] = M_STATUS;
            if (erase_blocked(err_q[wp]))
            begin
              // refused silently until status is cleared
            end
            else if (e_st_q != E_IDLE || prog_busy_q)
            begin
              err_set[wp] = SR_SEQ;
            end
            else if (!supply_ok_i)
            begin
              err_set[wp] = SR_SUPPLY;
            end
            else if (wb_locked)
            begin
              err_set[wp] = SR_LOCKED;
            end
            else
            begin
              start_erase = 1'b1;
            end
          end
          else
          begin
            // any other write breaks the sequence
            mode_d[pend_part_q] = M_STATUS;
            err_set[pend_part_q] = SR_SEQ;
          end
        end
        P_LOCK:
        begin
          if (cmd == CMD_LOCK || cmd == CMD_CONFIRM || cmd == CMD_LOCKDOWN)
          begin
            lock_op = 1'b1;
          end
          else
          begin
            mode_d[pend_part_q] = M_STATUS;
            err_set[pend_part_q] = SR_SEQ;
          end
        end
        P_PROG:
        begin
          mode_d[wp] = M_STATUS;
          if (e_st_q == E_RUN || prog_busy_q || (e_st_q == E_SUSP && wb == e_blk_q))
          begin
            err_set[wp] = SR_SEQ;
          end
          else if (!supply_ok_i)
          begin
            err_set[wp] = SR_SUPPLY;
          end
          else if (wb_locked)
          begin
            err_set[wp] = SR_LOCKED;
          end
          else
          begin
            start_prog = 1'b1;
          end
        end
        P_NONE:
        begin
          case (cmd)
            CMD_ERASE_SETUP:
            begin
              mode_d[wp] = M_STATUS;
              if (!erase_blocked(err_q[wp]))
              begin
                pend_d = P_ERASE;
                pend_part_d = wp;
              end
            end
            CMD_LOCK_SETUP:
            begin
              pend_d = P_LOCK;
              pend_part_d = wp;
            end
            CMD_PROG_SETUP:
            begin
              mode_d[wp] = M_STATUS;
              pend_d = P_PROG;
              pend_part_d = wp;
            end
            CMD_READ_STATUS: mode_d[wp] = M_STATUS;
            CMD_READ_ID: mode_d[wp] = M_ID;
            CMD_READ_ARRAY: mode_d[wp] = M_ARRAY;
            CMD_CLEAR_STATUS: err_clr[wp] = 1'b1;
            CMD_SUSPEND: do_suspend = (e_st_q == E_RUN);
            CMD_CONFIRM: do_resume = (e_st_q == E_SUSP) && !prog_busy_q;
            default: ;
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence and mode registers
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      pend_q <= P_NONE;
      pend_part_q <= '0;
      mode_q <= '{default: M_ARRAY};
    end
    else
    begin
      pend_q <= pend_d;
      pend_part_q <= pend_part_d;
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky error bits, a new error wins over clear
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      err_q <= '{default: SR_NONE};
    end
    else
    begin
      for (int i = 0; i < NUM_PART; i++)
      begin
        if (err_clr[i])
        begin
          err_q[i] <= err_set[i];
        end
        else
        begin
          err_q[i] <= err_q[i] | err_set[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // erase engine with suspend and resume
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      e_st_q <= E_IDLE;
      e_cnt_q <= '0;
      e_blk_q <= '0;
      e_part_q <= '0;
    end
    else if (start_erase)
    begin
      // address taken from the confirm write
      e_st_q <= E_RUN;
      e_cnt_q <= CNT_W'(ERASE_CYCLES - 1);
      e_blk_q <= wb;
      e_part_q <= wp;
    end
    else
    begin
      unique case (e_st_q)
        E_IDLE: ;
        E_RUN:
        begin
          if (erase_done)
          begin
            e_st_q <= E_IDLE;
          end
          else if (do_suspend)
          begin
            e_st_q <= E_SUSP;
          end
          else
          begin
            e_cnt_q <= e_cnt_q - 1'b1;
          end
        end
        E_SUSP:
        begin
          if (do_resume)
          begin
            e_st_q <= E_RUN;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program engine, also runs inside an erase suspend
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      prog_busy_q <= 1'b0;
      p_cnt_q <= '0;
      p_part_q <= '0;
    end
    else if (start_prog)
    begin
      prog_busy_q <= 1'b1;
      p_cnt_q <= CNT_W'(PROG_CYCLES - 1);
      p_part_q <= wp;
    end
    else if (prog_busy_q)
    begin
      if (p_cnt_q == '0)
      begin
        prog_busy_q <= 1'b0;
      end
      else
      begin
        p_cnt_q <= p_cnt_q - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array contents per block: erased or written
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      erased_q <= '0;
    end
    else
    begin
      if (erase_done)
      begin
        erased_q[e_blk_q] <= 1'b1;
      end
      if (start_prog)
      begin
        erased_q[wb] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock bits
  block_lock_bank u_lock_bank (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .op_valid_i(lock_op),
    .op_code_i(cmd),
    .op_blk_i(wb),
    .wp_n_i(wp_n_i),
    .lock_o(lock_w),
    .lockdown_o(lockdown_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || !rd_en_i)
    begin
      rd_data_o <= ZERO_WORD;
    end
    else
    begin
      unique case (mode_q[rp])
        M_STATUS: rd_data_o <= {8'h00, status_of(err_q[rp],
          (e_st_q == E_RUN && e_part_q == rp) || (prog_busy_q && p_part_q == rp),
          e_st_q == E_SUSP && e_part_q == rp)};
        M_ID:
        begin
          if (cmd_addr_i[OFS_W-1:0] == LOCK_STATUS_OFS)
          begin
            rd_data_o <= {14'h0000, lockdown_w[rb], rb_locked};
          end
          else
          begin
            rd_data_o <= ZERO_WORD;
          end
        end
        M_ARRAY: rd_data_o <= erased_q[rb] ? ERASED_WORD : ARRAY_FILL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine ready flag
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      engine_ready_o <= 1'b1;
    end
    else
    begin
      engine_ready_o <= !(e_st_q == E_RUN) && !prog_busy_q && !start_erase && !start_prog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_erase_seq;
    @(posedge ref_clk_i) disable iff (reset_i)
    start_erase |-> pend_q == P_ERASE && cmd == CMD_CONFIRM;
  endproperty
  a_erase_seq: assert property (p_erase_seq) else $error("erase started without setup and confirm");

  property p_no_overlap;
    @(posedge ref_clk_i) disable iff (reset_i)
    (e_st_q == E_RUN) |-> !prog_busy_q;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("program and erase running together");

  property p_confirm_addr;
    @(posedge ref_clk_i) disable iff (reset_i)
    start_erase |=> e_blk_q == $past(wb) && e_part_q == $past(wp);
  endproperty
  a_confirm_addr: assert property (p_confirm_addr) else $error("erase block not from confirm write");

  property p_erased_ones;
    @(posedge ref_clk_i) disable iff (reset_i)
    erase_done |=> erased_q[$past(e_blk_q)];
  endproperty
  a_erased_ones: assert property (p_erased_ones) else $error("erased block not all ones");

  property p_busy_ready;
    @(posedge ref_clk_i) disable iff (reset_i)
    start_erase |=> !engine_ready_o [*2];
  endproperty
  a_busy_ready: assert property (p_busy_ready) else $error("ready high during erase");

  property p_status_mode;
    @(posedge ref_clk_i) disable iff (reset_i)
    start_erase |=> mode_q[e_part_q] == M_STATUS;
  endproperty
  a_status_mode: assert property (p_status_mode) else $error("erasing partition not in status mode");

  property p_sticky(int g);
    @(posedge ref_clk_i) disable iff (reset_i)
    (|($past(err_q[g]) & ~err_q[g])) |-> $past(err_clr[g]);
  endproperty
  for (genvar g = 0; g < NUM_PART; g++)
  begin : g_sticky
    a_sticky: assert property (p_sticky(g)) else $error("error bit dropped without clear");
  end

  property p_locked_refused;
    @(posedge ref_clk_i) disable iff (reset_i)
    (wr_en_i && pend_q == P_ERASE && cmd == CMD_CONFIRM && wb_locked) |-> !start_erase;
  endproperty
  a_locked_refused: assert property (p_locked_refused) else $error("erase of protected block started");

  property p_reset_locked;
    @(posedge ref_clk_i) disable iff (reset_i)
    $past(reset_i) |-> (&lock_w) && !(|lockdown_w);
  endproperty
  a_reset_locked: assert property (p_reset_locked) else $error("blocks not locked after reset");

  property p_held;
    @(posedge ref_clk_i) disable iff (reset_i)
    (lock_op && !wp_n_i && lockdown_w[wb]) |=> lock_w == $past(lock_w) && lockdown_w == $past(lockdown_w);
  endproperty
  a_held: assert property (p_held) else $error("locked-down block changed while pin low");

  c_erase_done: cover property (@(posedge ref_clk_i) disable iff (reset_i) erase_done);
  c_seq_err: cover property (@(posedge ref_clk_i) disable iff (reset_i) err_set[0] == SR_SEQ);
  c_prog_in_susp: cover property (@(posedge ref_clk_i) disable iff (reset_i) start_prog && e_st_q == E_SUSP);
  c_lock_err: cover property (@(posedge ref_clk_i) disable iff (reset_i) err_set[0] == SR_LOCKED);

endmodule // block_erase_lock_ctrl

// File: inc/erase_lock_pkg.sv
// Purpose: shared constants and types for the block erase and lock control
// Assumes: 16-bit command port, 4 partitions of 4 blocks each
// Notes: status bit masks follow the write state engine status layout
package erase_lock_pkg;

  // address fields
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int PART_W = 2;
  localparam int BLK_W = 4;
  localparam int OFS_W = 8;
  localparam int NUM_PART = 4;
  localparam int NUM_BLK = 16;
  localparam int CNT_W = 16;

  // default busy lengths, in clock cycles
  localparam int unsigned ERASE_CYCLES_DEF = 64;
  localparam int unsigned PROG_CYCLES_DEF = 8;

  // command codes (low byte of the write data)
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;

  // wsm_status bits
  localparam logic [7:0] SR_READY = 8'h80;
  localparam logic [7:0] SR_ESUSP = 8'h40;
  localparam logic [7:0] SR_ERASE_ERR = 8'h20;
  localparam logic [7:0] SR_SEQ = 8'h30;
  localparam logic [7:0] SR_SUPPLY = 8'h08;
  localparam logic [7:0] SR_LOCKED = 8'h02;
  localparam logic [7:0] SR_ERR_MASK = 8'h3A;
  localparam logic [7:0] SR_NONE = 8'h00;

  // identifier-mode offset of the lock status word
  localparam logic [OFS_W-1:0] LOCK_STATUS_OFS = 8'h02;

  // array read words
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [DATA_W-1:0] ARRAY_FILL = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // per-block lock reset values
  localparam logic LOCK_RESET = 1'b1;
  localparam logic LOCKDOWN_RESET = 1'b0;

  // partition read mode
  typedef enum logic [2:0] {
    M_ARRAY = 3'b001,
    M_STATUS = 3'b010,
    M_ID = 3'b100
  } mode_t;

  // pending first half of a two-write sequence
  typedef enum logic [3:0] {
    P_NONE = 4'b0001,
    P_ERASE = 4'b0010,
    P_LOCK = 4'b0100,
    P_PROG = 4'b1000
  } pend_t;

  // erase engine state
  typedef enum logic [2:0] {
    E_IDLE = 3'b001,
    E_RUN = 3'b010,
    E_SUSP = 3'b100
  } erase_st_t;

endpackage

// File: core/block_lock_bank.sv
// Purpose: per-block lock and lock-down bits
// Assumes: one lock command per cycle from the command front end
// Notes: lock-down bits leave only through reset
`timescale 1ns/1ns
module block_lock_bank
  import erase_lock_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic op_valid_i,
  input wire logic [7:0] op_code_i,
  input wire logic [BLK_W-1:0] op_blk_i,
  input wire logic wp_n_i,
  output logic [NUM_BLK-1:0] lock_o,
  output logic [NUM_BLK-1:0] lockdown_o
);

  logic [NUM_BLK-1:0] lock_q; // lock bit per block
  logic [NUM_BLK-1:0] lockdown_q; // lock-down bit per block
  logic held; // addressed block held locked-down

  ////////////////////////////////////////////////////////////////////////////
  // hold check: pin low plus lock-down freezes the block
  assign held = lockdown_q[op_blk_i] & ~wp_n_i;

  ////////////////////////////////////////////////////////////////////////////
  // lock bit and lock-down bit updates
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      // all blocks locked, lock-down gone
      lock_q <= {NUM_BLK{LOCK_RESET}};
      lockdown_q <= {NUM_BLK{LOCKDOWN_RESET}};
    end
    else if (op_valid_i && !held)
    begin
      // pin high lets commands act again on locked-down blocks
      case (op_code_i)
        CMD_LOCK: lock_q[op_blk_i] <= 1'b1;
        CMD_CONFIRM: lock_q[op_blk_i] <= 1'b0;
        CMD_LOCKDOWN:
        begin
          lock_q[op_blk_i] <= 1'b1;
          lockdown_q[op_blk_i] <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  assign lock_o = lock_q;
  assign lockdown_o = lockdown_q;

endmodule // block_lock_bank

// File: testbench/host_bus_model.sv
// Purpose: host bus master model that drives the command port
// Assumes: one write or read per call, strobes one cycle long
// Notes: address and data are inverted while no strobe is up
`timescale 1ns/1ns
module host_bus_model
  import erase_lock_pkg::*;
(
  input wire logic ref_clk_i,
  output logic [ADDR_W-1:0] cmd_addr_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic wr_en_o,
  output logic rd_en_o,
  input wire logic [DATA_W-1:0] rd_data_i
);
  ////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial
  begin
    cmd_addr_o = '0;
    wr_data_o = '0;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
  end

  // one write cycle, callers send two-write sequences with nothing between
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] c);
    @(posedge ref_clk_i);
    cmd_addr_o <= a;
    wr_data_o <= {8'hA5, c};
    wr_en_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_o <= 1'b0;
    cmd_addr_o <= ~a;
    wr_data_o <= ~{8'hA5, c};
  endtask

  // one read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    cmd_addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_o <= 1'b0;
    cmd_addr_o <= ~a;
    #1 d = rd_data_i;
  endtask
endmodule // host_bus_model

// File: testbench/tb.sv
// Purpose: self-checking bench for block erase and lock control
// Assumes: short erase and program counts set as parameters
// Notes: partition 0 holds blocks 0-3, partition 1 blocks 4-7
`timescale 1ns/1ns
module tb;
  import erase_lock_pkg::*;
  logic ref_clk_i = 1'b0; // bench clock
  logic reset_i = 1'b1; // held for 5 cycles
  logic wp_n_i = 1'b1; // protect pin released
  logic supply_ok_i = 1'b1; // supply above lockout
  logic [ADDR_W-1:0] cmd_addr_i;
  logic [DATA_W-1:0] wr_data_i;
  logic wr_en_i;
  logic rd_en_i;
  logic [DATA_W-1:0] rd_data_o;
  logic engine_ready_o;
  logic [DATA_W-1:0] d; // last read word
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  block_erase_lock_ctrl #(.ERASE_CYCLES(16), .PROG_CYCLES(2)) dut (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .cmd_addr_i(cmd_addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .wp_n_i(wp_n_i), .supply_ok_i(supply_ok_i), .rd_data_o(rd_data_o),
    .engine_ready_o(engine_ready_o));
  host_bus_model host (.ref_clk_i(ref_clk_i), .cmd_addr_o(cmd_addr_i), .wr_data_o(wr_data_i),
    .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .rd_data_i(rd_data_o));

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // compare a read word
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp)
      $display("ERROR %0t word got %h exp %h", $time, got, exp);
    if (got !== exp)
      mismatches++;
  endtask

  // compare the ready flag
  task automatic chkf(input logic exp);
    checks++;
    if (engine_ready_o !== exp)
      $display("ERROR %0t ready flag got %b exp %b", $time, engine_ready_o, exp);
    if (engine_ready_o !== exp)
      mismatches++;
  endtask

  function automatic logic [ADDR_W-1:0] ba(input int b, input logic [7:0] o);
    return {BLK_W'(b), o};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // command helpers
  task automatic st(input int b, input logic [7:0] e);
    host.wr(ba(b, 8'h00), CMD_READ_STATUS);
    host.rd(ba(b, 8'h00), d);
    chk(d, {8'h00, e});
  endtask
  task automatic id(input int b, input logic [1:0] e);
    host.wr(ba(b, 8'h00), CMD_READ_ID);
    host.rd(ba(b, LOCK_STATUS_OFS), d);
    chk(d, {14'h0000, e});
  endtask
  task automatic arr(input int b, input logic [DATA_W-1:0] e);
    host.wr(ba(b, 8'h00), CMD_READ_ARRAY);
    host.rd(ba(b, 8'h10), d);
    chk(d, e);
  endtask
  task automatic lk(input int b, input logic [7:0] c);
    host.wr(ba(b, 8'h00), CMD_LOCK_SETUP);
    host.wr(ba(b, 8'h04), c);
  endtask
  task automatic er(input int bs, input int bc);
    host.wr(ba(bs, 8'h00), CMD_ERASE_SETUP);
    host.wr(ba(bc, 8'h08), CMD_CONFIRM);
  endtask
  task automatic clr(input int b);
    host.wr(ba(b, 8'h00), CMD_CLEAR_STATUS);
  endtask
  // bounded wait for the engine to finish
  task automatic wait_ready();
    // settle first so a start in this edge is seen as busy
    #1;
    for (int i = 0; i < 60 && engine_ready_o !== 1'b1; i++)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    chkf(1'b1);
  endtask
  task automatic rst();
    reset_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    rst();
    #1 chkf(1'b1);
    id(1, 2'b01);
    er(1, 1);
    st(1, SR_READY | SR_LOCKED);
    arr(1, ZERO_WORD);
    lk(1, CMD_CONFIRM);
    id(1, 2'b00);
    er(1, 1);
    #1 chkf(1'b1);
    st(1, SR_READY | SR_LOCKED);
    clr(1);
    st(1, SR_READY);
    $display("test locked erase done");
    er(5, 1);
    host.rd(ba(1, 8'h00), d);
    chk(d, {8'h00, SR_NONE});
    chkf(1'b0);
    host.wr(ba(8, 8'h00), CMD_PROG_SETUP);
    host.wr(ba(8, 8'h00), 8'h00);
    wait_ready();
    host.rd(ba(1, 8'h00), d);
    chk(d, {8'h00, SR_READY});
    st(8, SR_READY | SR_SEQ);
    arr(1, ERASED_WORD);
    arr(5, ZERO_WORD);
    clr(8);
    $display("test erase done");
    lk(2, CMD_CONFIRM);
    host.wr(ba(2, 8'h00), CMD_ERASE_SETUP);
    host.wr(ba(2, 8'h00), CMD_READ_STATUS);
    st(2, SR_READY | SR_SEQ);
    er(2, 2);
    #1 chkf(1'b1);
    st(2, SR_READY | SR_SEQ);
    clr(2);
    lk(3, 8'h77);
    st(3, SR_READY | SR_SEQ);
    clr(3);
    supply_ok_i <= 1'b0;
    er(2, 2);
    st(2, SR_READY | SR_SUPPLY);
    lk(2, CMD_LOCK);
    id(2, 2'b01);
    supply_ok_i <= 1'b1;
    clr(2);
    $display("test errors done");
    wp_n_i <= 1'b0;
    lk(3, CMD_LOCKDOWN);
    id(3, 2'b11);
    lk(3, CMD_CONFIRM);
    id(3, 2'b11);
    wp_n_i <= 1'b1;
    lk(3, CMD_CONFIRM);
    id(3, 2'b10);
    er(3, 3);
    host.wr(ba(3, 8'h00), CMD_SUSPEND);
    st(3, SR_READY | SR_ESUSP);
    host.wr(ba(1, 8'h00), CMD_PROG_SETUP);
    host.wr(ba(1, 8'h00), 8'h00);
    st(1, SR_READY | SR_ESUSP);
    host.wr(ba(3, 8'h00), CMD_CONFIRM);
    @(posedge ref_clk_i);
    #1 chkf(1'b0);
    wait_ready();
    arr(3, ERASED_WORD);
    rst();
    id(3, 2'b01);
    id(1, 2'b01);
    $display("test locking done");
    stop_test();
  end
endmodule // tb
